// *** rtl/board_cache_pkg.sv ***
// Purpose: shared constants and types for the board cache sequencer
// Assumes: one cpu clock domain plus a system clock domain
// Notes: config fields arrive as plain register words on ports
package board_cache_pkg;
  localparam int DATA_W = 128;
  localparam int INDEX_W = 22;
  localparam int BEATS = 4;
  // field positions in the two config words
  localparam int RD_LSB = 4;
  localparam int WR_LSB = 8;
  localparam int SPD_W = 4;
  localparam int WE_LSB = 20;
  localparam int WE_W = 9;
  localparam int WAVE_HI_BIT = 31;
  localparam int WAVE_LO_LSB = 17;
  localparam int FLUSH_BIT = 26;
  // timing limits in cpu cycles, then the last beat numbers
  localparam logic [3:0] CYC_MIN = 4'h4;
  localparam logic [3:0] CYC_MIN32 = 4'h5;
  localparam logic [3:0] CYC_MAX = 4'ha;
  localparam logic [3:0] PERIOD_MIN = 4'h3;
  localparam logic [3:0] SCLK_HIGH = 4'h2;
  localparam logic [1:0] LAST64 = 2'h3;
  localparam logic [1:0] LAST32 = 2'h1;

  typedef enum logic [1:0] {
    PRIV_RD,
    PRIV_WR,
    SYS_RD,
    FILL
  } txn_type;

  typedef enum logic [1:0] {
    IDLE,
    WAIT_SYS,
    BEAT,
    DRAIN
  } state_type;
endpackage : board_cache_pkg

// *** rtl/toggle_sync.sv ***
// Purpose: carry a toggle event into another clock domain
// Assumes: toggles are spaced by the handshake, never faster
// Notes: first stage feeds only the second stage
module toggle_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // toggle from the far domain
  input wire logic tog_i,
  // local view
  output logic level_o,
  output logic pulse_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  // two-stage synchroniser plus an edge register
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= tog_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level_o = s3_q;
  assign pulse_o = s2_q ^ s3_q;
endmodule : toggle_sync

// *** rtl/board_cache_sram_timing.sv ***
// Purpose: sequence private and system transfers to board cache srams
// Assumes: srams answer within the programmed latency on the cpu clock
// Notes: pins lag the internal counters by one register stage; write data, its enable and a delayed clock copy by two
module board_cache_sram_timing #(
  parameter int DATA_W = board_cache_pkg::DATA_W,
  parameter int INDEX_W = board_cache_pkg::INDEX_W
) (
  // clocks and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sys_clk_i,
  // configuration words and straps
  input wire logic [31:0] cache_config_reg_i,
  input wire logic [31:0] cache_control_reg_i,
  input wire logic block_64_i,
  input wire logic enhanced_i,
  input wire logic clk_delay_a_i,
  input wire logic clk_delay_b_i,
  // transaction request
  input wire logic req_valid_i,
  input wire board_cache_pkg::txn_type req_type_i,
  input wire logic [INDEX_W-1:0] req_index_i,
  input wire logic [board_cache_pkg::BEATS*DATA_W-1:0] req_wdata_i,
  output logic req_ready_o,
  // read return and status
  output logic [DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic [1:0] rdata_beat_o,
  output logic done_o,
  output logic busy_o,
  // system side, on the system clock
  input wire logic dack_i,
  // cache pins
  output logic [INDEX_W-1:0] index_o,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [DATA_W-1:0] data_i,
  output logic tag_oe_o,
  output logic data_ram_oe_o,
  output logic tag_we_o,
  output logic data_we_o,
  output logic sram_clock_out_a_o,
  output logic sram_clock_out_b_o
);
  board_cache_pkg::state_type state_q, state_d;
  board_cache_pkg::txn_type type_q;
  logic [3:0] cyc_q;
  logic [1:0] beat_q;
  logic [5:0] tot_q;
  logic [5:0] samp_q;
  logic [2:0] nsamp_q;
  logic started_q;
  logic [3:0] per_q;
  logic [3:0] lat_q;
  logic [1:0] last_q;
  logic blk_q;
  logic enh_q;
  logic [8:0] mask_q;
  logic [INDEX_W-1:0] base_q;
  logic [board_cache_pkg::BEATS*DATA_W-1:0] wdata_q;
  logic dvalid_q;
  logic [1:0] dbeat_q;
  logic sclk_q;
  logic [2:0] pend_q;
  logic [2:0] dcnt_s_q;
  logic req_tog_s_q;
  // config field decode, clamped to the legal window
  wire [3:0] rd_field = cache_config_reg_i[board_cache_pkg::RD_LSB +:
                                           board_cache_pkg::SPD_W];
  wire [3:0] wr_field = cache_config_reg_i[board_cache_pkg::WR_LSB +:
                                           board_cache_pkg::SPD_W];
  wire [8:0] we_field = cache_config_reg_i[board_cache_pkg::WE_LSB +:
                                           board_cache_pkg::WE_W];
  wire [3:0] wave = {1'b0,
    cache_control_reg_i[board_cache_pkg::WAVE_HI_BIT],
    cache_control_reg_i[board_cache_pkg::WAVE_LO_LSB +: 2]};
  wire [3:0] rd_min = block_64_i ? board_cache_pkg::CYC_MIN
                                 : board_cache_pkg::CYC_MIN32;
  wire [3:0] rd_lat = (rd_field < rd_min) ? rd_min :
                      (rd_field > board_cache_pkg::CYC_MAX) ?
                      board_cache_pkg::CYC_MAX : rd_field;
  wire [3:0] wr_cyc = (wr_field < board_cache_pkg::CYC_MIN) ?
                      board_cache_pkg::CYC_MIN :
                      (wr_field > board_cache_pkg::CYC_MAX) ?
                      board_cache_pkg::CYC_MAX : wr_field;
  // request classification
  wire req_rd = (req_type_i == board_cache_pkg::PRIV_RD) ||
                (req_type_i == board_cache_pkg::SYS_RD);
  wire req_sys = (req_type_i == board_cache_pkg::SYS_RD) ||
                 (req_type_i == board_cache_pkg::FILL);
  // overlap only for private reads of 64-byte blocks
  wire wave_on = block_64_i && (wave != 4'h0) &&
                 (req_type_i == board_cache_pkg::PRIV_RD);
  // floor keeps a bad setting from collapsing the period to zero
  wire [3:0] rd_per = !wave_on ? rd_lat :
                      ((wave + board_cache_pkg::PERIOD_MIN) > rd_lat) ?
                      board_cache_pkg::PERIOD_MIN : rd_lat - wave;
  wire [3:0] req_per = req_rd ? rd_per : wr_cyc;
  // transaction state decode
  wire is_rd = (type_q == board_cache_pkg::PRIV_RD) ||
               (type_q == board_cache_pkg::SYS_RD);
  wire is_sys = (type_q == board_cache_pkg::SYS_RD) ||
                (type_q == board_cache_pkg::FILL);
  wire in_beat = (state_q == board_cache_pkg::BEAT);
  wire start = (state_q == board_cache_pkg::IDLE) && req_valid_i;
  wire beat_end = in_beat && (cyc_q == per_q - 4'h1);
  wire last_beat = (beat_q == last_q);
  wire [2:0] nbeats = {1'b0, last_q} + 3'h1;
  wire cap = is_rd && (state_q != board_cache_pkg::IDLE) &&
             (tot_q == samp_q) && (nsamp_q != nbeats);
  wire drain_done = !is_rd || (cap && (nsamp_q == {1'b0, last_q}));
  // a system beat needs an acknowledge crossed from the system edge
  wire sys_go = (pend_q != 3'h0);
  wire take = (state_q == board_cache_pkg::WAIT_SYS) && sys_go;
  wire dack_pulse;
  wire dack_level;
  wire ack_s;
  // next state; private transfers start at once, system ones wait
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      board_cache_pkg::IDLE: begin
        if (req_valid_i) begin
          state_d = req_sys ? board_cache_pkg::WAIT_SYS
                            : board_cache_pkg::BEAT;
        end
      end
      board_cache_pkg::WAIT_SYS: begin
        if (sys_go) begin
          state_d = board_cache_pkg::BEAT;
        end
      end
      board_cache_pkg::BEAT: begin
        if (beat_end) begin
          state_d = last_beat ? board_cache_pkg::DRAIN :
                    is_sys ? board_cache_pkg::WAIT_SYS :
                    board_cache_pkg::BEAT;
        end
      end
      board_cache_pkg::DRAIN: begin
        if (drain_done) begin
          state_d = board_cache_pkg::IDLE;
        end
      end
    endcase
  end
  // pin values one stage ahead of the pin registers
  wire rd_oe_d = is_rd && started_q &&
                 (in_beat || (state_q == board_cache_pkg::WAIT_SYS));
  wire we_bit = (cyc_q < 4'(board_cache_pkg::WE_W)) && mask_q[cyc_q];
  wire we_d = !is_rd && in_beat && we_bit;
  wire late_clk = !is_rd && enh_q;
  wire sclk_d = in_beat && (late_clk ?
                (cyc_q >= 4'h1) && (cyc_q <= board_cache_pkg::SCLK_HIGH) :
                (cyc_q < board_cache_pkg::SCLK_HIGH));
  wire [INDEX_W-1:0] index_d = base_q + INDEX_W'(beat_q);
  wire [DATA_W-1:0] wdata_d = wdata_q[dbeat_q * DATA_W +: DATA_W];
  // state and per-transaction settings, latched so rates never mix
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= board_cache_pkg::IDLE;
      type_q <= board_cache_pkg::PRIV_RD;
      per_q <= board_cache_pkg::CYC_MIN;
      lat_q <= board_cache_pkg::CYC_MIN;
      last_q <= board_cache_pkg::LAST64;
      blk_q <= 1'b0;
      enh_q <= 1'b0;
      mask_q <= '0;
      base_q <= '0;
      wdata_q <= '0;
    end else begin
      state_q <= state_d;
      if (start) begin
        type_q <= req_type_i;
        per_q <= req_per;
        lat_q <= rd_lat;
        last_q <= block_64_i ? board_cache_pkg::LAST64
                             : board_cache_pkg::LAST32;
        blk_q <= block_64_i;
        enh_q <= enhanced_i;
        mask_q <= we_field;
        base_q <= req_index_i;
        wdata_q <= req_wdata_i;
      end
    end
  end

  // beat and cycle counters
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cyc_q <= '0;
      beat_q <= '0;
      started_q <= 1'b0;
    end else if (start) begin
      cyc_q <= '0;
      beat_q <= '0;
      started_q <= 1'b0;
    end else if (in_beat) begin
      cyc_q <= beat_end ? 4'h0 : cyc_q + 4'h1;
      beat_q <= (beat_end && !last_beat) ? beat_q + 2'h1 : beat_q;
      started_q <= !(beat_end && last_beat);
    end
  end

  // running time and the next read sample point
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tot_q <= '0;
      samp_q <= '0;
      nsamp_q <= '0;
    end else if (start) begin
      tot_q <= '0;
      samp_q <= 6'(rd_lat);
      nsamp_q <= '0;
    end else begin
      if (in_beat || (state_q == board_cache_pkg::DRAIN)) begin
        tot_q <= tot_q + 6'h01;
      end
      if (cap) begin
        samp_q <= samp_q + 6'(per_q);
        nsamp_q <= nsamp_q + 3'h1;
      end
    end
  end

  // cache pin registers; fill data comes from the system, not us
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dvalid_q <= 1'b0;
      dbeat_q <= '0;
      sram_clock_out_a_o <= 1'b0;
      sram_clock_out_b_o <= 1'b0;
      index_o <= '0;
      data_o <= '0;
      data_oe_o <= 1'b0;
      tag_oe_o <= 1'b0;
      data_ram_oe_o <= 1'b0;
      tag_we_o <= 1'b0;
      data_we_o <= 1'b0;
      sclk_q <= 1'b0;
    end else begin
      dvalid_q <= in_beat && (type_q == board_cache_pkg::PRIV_WR);
      dbeat_q <= beat_q; // write data trails its index by one cycle
      // each clock copy may slip one cycle on its own
      sram_clock_out_a_o <= clk_delay_a_i ? sclk_q : sclk_d;
      sram_clock_out_b_o <= clk_delay_b_i ? sclk_q : sclk_d;
      index_o <= index_d;
      data_o <= wdata_d;
      data_oe_o <= dvalid_q;
      tag_oe_o <= rd_oe_d;
      data_ram_oe_o <= rd_oe_d;
      tag_we_o <= we_d;
      data_we_o <= we_d;
      sclk_q <= sclk_d;
    end
  end

  // read return and status
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
      rdata_beat_o <= '0;
      done_o <= 1'b0;
      busy_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      if (cap) begin
        rdata_o <= data_i;
        rdata_beat_o <= nsamp_q[1:0];
      end
      rdata_valid_o <= cap;
      done_o <= (state_q == board_cache_pkg::DRAIN) && drain_done;
      busy_o <= (state_d != board_cache_pkg::IDLE);
      req_ready_o <= (state_d == board_cache_pkg::IDLE);
    end
  end

  // crossed acknowledges; a new one and a beat taking one in the same cycle both count
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pend_q <= '0;
    end else if (state_q == board_cache_pkg::IDLE) begin
      pend_q <= {2'h0, dack_pulse};
    end else begin
      pend_q <= pend_q + {2'h0, dack_pulse} - {2'h0, take};
    end
  end

  // system side: count acknowledges, launch one toggle at a time
  wire send_s = (dcnt_s_q != 3'h0) && (ack_s == req_tog_s_q);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dcnt_s_q <= '0;
      req_tog_s_q <= 1'b0;
    end else begin
      dcnt_s_q <= dcnt_s_q + {2'h0, dack_i} - {2'h0, send_s};
      if (send_s) begin
        req_tog_s_q <= !req_tog_s_q;
      end
    end
  end

  // system edge event into the cpu domain
  toggle_sync u_to_cpu (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .tog_i(req_tog_s_q),
    .level_o(dack_level),
    .pulse_o(dack_pulse)
  );

  // acknowledge back to the system domain
  toggle_sync u_to_sys (
    .clk_i(sys_clk_i),
    .reset_i(reset_i),
    .tog_i(dack_level),
    .level_o(ack_s),
    .pulse_o()
  );

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // checks
  a_sclk_idle_low: assert property (
    (state_q == board_cache_pkg::IDLE) |=> !sclk_q)
    else $error("sram clock high while idle");
  a_sclk_two_high: assert property (
    $rose(sclk_q) |-> sclk_q [*2] ##1 !sclk_q)
    else $error("sram clock pulse not two cycles");
  a_oe_one_late: assert property (
    (start && req_rd && !req_sys) |=> ##1 !tag_oe_o ##1 tag_oe_o)
    else $error("read enable not one cycle after index");
  a_we_zero_mask: assert property (
    (in_beat && !is_rd && mask_q == 9'h000) |=> !data_we_o)
    else $error("write enable with zero mask");
  a_we_first_bit: assert property (
    (in_beat && !is_rd && cyc_q == 4'h0) |=>
      (data_we_o == $past(mask_q[0])))
    else $error("first write cycle ignores mask bit");
  a_wdata_late: assert property (
    (in_beat && type_q == board_cache_pkg::PRIV_WR && cyc_q == 4'h0)
      |=> ##1 data_oe_o)
    else $error("write data not one cycle after index");
  a_read_bus_free: assert property (
    (is_rd && state_q == board_cache_pkg::DRAIN) |=> !data_oe_o)
    else $error("data bus driven during read");
  a_sys_needs_dack: assert property (
    (state_q == board_cache_pkg::WAIT_SYS && pend_q == 3'h0)
      |=> (state_q != board_cache_pkg::BEAT))
    else $error("system beat without acknowledge");
  a_no_wave_32: assert property (
    (in_beat && is_rd && !blk_q) |-> (per_q == lat_q))
    else $error("overlapped read with 32-byte blocks");
  a_rate_held: assert property (
    (state_q != board_cache_pkg::IDLE && !start) |=> $stable(per_q))
    else $error("rate changed inside a transaction");
  a_period_legal: assert property (
    in_beat |-> (per_q >= board_cache_pkg::PERIOD_MIN &&
                 per_q <= board_cache_pkg::CYC_MAX))
    else $error("beat period out of range");

  c_priv_read: cover property (
    (type_q == board_cache_pkg::PRIV_RD) && done_o);
  c_wave_read: cover property (in_beat && is_rd && (per_q < lat_q));
  c_fill_done: cover property ((type_q == board_cache_pkg::FILL) && done_o);
endmodule : board_cache_sram_timing

// *** tb/cache_far_side.sv ***
// Purpose: far side of the board cache, sram bank plus system pacing
// Assumes: read data is a fixed pattern of the index on the pins
// Notes: an unselected bus shows the inverse of its last value
module cache_far_side (
  // clocks and reset
  input wire logic clk_i,
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // cache pins
  input wire logic [21:0] index_i,
  input wire logic oe_i,
  input wire logic [3:0] lat_i,
  output logic [127:0] data_o,
  // system pacing from the bench
  input wire logic go_i,
  input wire logic slow_i,
  input wire logic [2:0] beats_i,
  output logic dack_o
);
  logic [2:0] sent_q;
  logic [5:0] gap_q;
  logic [21:0] ih[16];
  logic oh[16];
  initial data_o = '0;
  // data lands lat_i - 2 cycles after its index reaches the pins, so wave reads overlap;
  // only an enabled read returns the pattern, a stale value never passes
  always @(posedge clk_i) begin
    for (int i = 15; i > 0; i--) begin
      ih[i] <= ih[i-1];
      oh[i] <= oh[i-1];
    end
    ih[0] <= index_i;
    oh[0] <= oe_i;
    if (oh[lat_i - 4'h4]) data_o <= {4{ih[lat_i - 4'h4], 10'h2a5}};
    else data_o <= ~data_o;
  end
  // one acknowledge per beat, prompt or slow
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sent_q <= '0;
      gap_q <= '0;
      dack_o <= 1'b0;
    end else begin
      dack_o <= 1'b0;
      if (!go_i) begin
        sent_q <= '0;
        gap_q <= '0;
      end else if (sent_q != beats_i) begin
        if (gap_q == (slow_i ? 6'h3c : 6'h0c)) begin
          dack_o <= 1'b1;
          sent_q <= sent_q + 3'h1;
          gap_q <= '0;
        end else begin
          gap_q <= gap_q + 6'h01;
        end
      end
    end
  end
endmodule : cache_far_side

// *** tb/tb_board_cache_sram_timing.sv ***
// Purpose: self-checking bench for the board cache sequencer
// Assumes: far side model answers reads and paces system beats
// Notes: driver queues expectations, the monitor pops and compares
module tb_board_cache_sram_timing;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("BAD %0t got %0h want %0h", $time, g, e); end end
  typedef struct {logic [127:0] d; logic [1:0] beat; int gap;} note_type;
  logic clk_i = 0, sys_clk_i = 0, reset_i = 1;
  logic [31:0] cfg = '0, ctl = '0;
  logic b64 = 1, enh = 0, dla = 0, dlb = 0, rv = 0, go = 0, slow = 0;
  board_cache_pkg::txn_type ty = board_cache_pkg::PRIV_RD;
  logic [21:0] idx = '0, index;
  logic [511:0] wd = '0;
  logic [127:0] rdata, data_o, data_i, prev_d, w;
  logic rdv, done, busy, ready, dack, doe, toe, roe, twe, dwe, ca, cb;
  logic prev_oe = 0;
  logic [1:0] rbeat;
  logic [3:0] rl = 4'h4;
  int errors = 0, n_checks = 0, cyc = 0, last = 0;
  int we_cnt, ca_cnt, cb_cnt, odd, seed = 32'hb47b_2bbc;
  logic [3:0] lt[5] = '{4'h4, 4'h6, 4'ha, 4'h2, 4'hf};
  logic [3:0] wt[4] = '{4'h4, 4'ha, 4'h2, 4'hf};
  logic [8:0] mk[4] = '{9'h000, 9'h1ff, 9'h006, 9'h001};
  note_type rq[$];
  logic [127:0] wq[$];

  always #25 clk_i = ~clk_i;
  // link clock with its own phase
  initial begin
    #1.3;
    forever #3 sys_clk_i = ~sys_clk_i;
  end

  board_cache_sram_timing u_board_cache_sram_timing (
    .clk_i(clk_i), .reset_i(reset_i), .sys_clk_i(sys_clk_i),
    .cache_config_reg_i(cfg), .cache_control_reg_i(ctl),
    .block_64_i(b64), .enhanced_i(enh), .clk_delay_a_i(dla),
    .clk_delay_b_i(dlb), .req_valid_i(rv), .req_type_i(ty),
    .req_index_i(idx), .req_wdata_i(wd), .req_ready_o(ready),
    .rdata_o(rdata), .rdata_valid_o(rdv), .rdata_beat_o(rbeat),
    .done_o(done), .busy_o(busy), .dack_i(dack), .index_o(index),
    .data_o(data_o), .data_oe_o(doe), .data_i(data_i), .tag_oe_o(toe),
    .data_ram_oe_o(roe), .tag_we_o(twe), .data_we_o(dwe),
    .sram_clock_out_a_o(ca), .sram_clock_out_b_o(cb));

  cache_far_side u_cache_far_side (
    .clk_i(clk_i), .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .index_i(index), .oe_i(roe), .lat_i(rl), .data_o(data_i), .go_i(go),
    .slow_i(slow), .beats_i(b64 ? 3'h4 : 3'h2), .dack_o(dack));

  // watch pins on the falling edge, where every output has settled
  always @(negedge clk_i) begin
    note_type n;
    cyc++;
    if (rdv === 1'b1) begin
      if (rq.size() == 0) odd++;
      else begin
        n = rq.pop_front();
        `CHK(rdata, n.d)
        `CHK(rbeat, n.beat)
        if (n.gap > 0) `CHK(cyc - last, n.gap)
        last = cyc;
      end
    end
    // a new write beat shows as a rise of the enable or fresh data
    if (doe === 1'b1 && (!prev_oe || data_o !== prev_d)) begin
      if (wq.size() == 0) odd++;
      else begin
        w = wq.pop_front();
        `CHK(data_o, w)
      end
    end
    prev_oe = doe;
    prev_d = data_o;
    we_cnt += (dwe === 1'b1);
    ca_cnt += (ca === 1'b1);
    cb_cnt += (cb === 1'b1);
    if (twe !== dwe || toe !== roe) odd++;
    if (busy === 1'b0 && (ca | cb) !== 1'b0) odd++;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  // one whole transaction: queue expectations, request, await the end
  task automatic do_txn(input logic [1:0] t, input logic [3:0] lat,
                        input logic [3:0] wc, input logic [8:0] mask,
                        input logic [2:0] wave);
    int p, wn, nb, k, mn;
    note_type n;
    nb = b64 ? 4 : 2;
    mn = b64 ? 4 : 5;
    p = lat < mn ? mn : (lat > 10 ? 10 : int'(lat));
    if (b64 && t == 0 && wave != 0) p = lat - wave < 3 ? 3 : lat - wave;
    wn = wc < 4 ? 4 : (wc > 10 ? 10 : int'(wc));
    while (ready !== 1'b1) @(posedge clk_i) #2;
    rl = 4'(lat < mn ? mn : (lat > 10 ? 10 : int'(lat)));
    cfg = {3'h0, mask, 8'h00, wc, lat, 4'h0};
    ctl = {wave[2], 4'h0, 1'b1, 7'h00, wave[1:0], 17'h0_0000};
    idx = 22'($random(seed));
    for (k = 0; k < 16; k++) wd[k*32 +: 32] = $random(seed);
    dla = 1'($random(seed));
    dlb = 1'($random(seed));
    ty = board_cache_pkg::txn_type'(t);
    for (k = 0; k < nb; k++) begin
      n.d = {4{22'(idx + k), 10'h2a5}};
      n.beat = 2'(k);
      n.gap = (t == 0 && k > 0) ? p : 0;
      if (t == 0 || t == 2) rq.push_back(n);
      if (t == 1) wq.push_back(wd[k*128 +: 128]);
    end
    we_cnt = 0;
    ca_cnt = 0;
    cb_cnt = 0;
    odd = 0;
    rv = 1;
    @(posedge clk_i) #2;
    rv = 0;
    go = t[1];
    for (k = 0; k < 3000 && done !== 1'b1; k++) @(posedge clk_i) #2;
    `CHK(done, 1'b1)
    go = 0;
    @(posedge clk_i) #2;
    `CHK(rq.size() + wq.size(), 0)
    `CHK(odd, 0)
    `CHK(ca_cnt, 2 * nb)
    `CHK(cb_cnt, 2 * nb)
    k = $countones(mask & ((9'h1 << wn) - 1));
    if (t == 1) `CHK(we_cnt, nb * k)
    $display("test done type %0d lat %0d wr %0d", t, lat, wc);
  endtask : do_txn

  initial begin
    #(50 * 60000);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    #2 reset_i = 0;
    // plain reads across latency, clamped at both ends
    foreach (lt[i]) do_txn(0, lt[i], 4'h4, 9'h000, 3'h0);
    // wave pipelined reads; software keeps the interval above 2
    do_txn(0, 4'h6, 4'h4, 9'h000, 3'h2);
    do_txn(0, 4'h7, 4'h4, 9'h000, 3'h4);
    // pulse masks and write times, both parts
    for (int i = 0; i < 4; i++) begin
      enh = i[0];
      do_txn(1, 4'h4, wt[i], mk[i], 3'h0);
    end
    // first-cycle enable, then a read straight after the write
    do_txn(1, 4'h5, 4'h5, 9'h001, 3'h0);
    do_txn(0, 4'h5, 4'h5, 9'h001, 3'h0);
    // system reads and fills, prompt then slow
    for (int i = 0; i < 2; i++) begin
      slow = i[0];
      do_txn(2, 4'h6, 4'h4, 9'h001, 3'h0);
      do_txn(3, 4'h6, 4'h4, 9'h001, 3'h0);
    end
    // 32-byte blocks ignore the wave count, minimum read is longer
    b64 = 0;
    do_txn(0, 4'h4, 4'h4, 9'h000, 3'h2);
    do_txn(1, 4'h4, 4'h4, 9'h1ff, 3'h0);
    do_txn(2, 4'h6, 4'h4, 9'h001, 3'h0);
    tally_and_finish();
  end
endmodule : tb_board_cache_sram_timing
